//--- logic/cbaf_current_block_access_filter.v
// Current block access filter: grants, arbitration and feedback filtering.
// Assumes channel requests and feedbacks are synchronous to sys_clk.
`timescale 1ns/100ps
`include "cbaf_consts.vh"
module cbaf_current_block_access_filter (
  input wire sys_clk,
  input wire srst,
  input wire [`CBAF_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [`CBAF_TARGETS-1:0] core_zero_channel_one_req,
  input wire [`CBAF_TARGETS*`CBAF_CTRL_W-1:0] core_zero_channel_one_data,
  input wire [`CBAF_TARGETS-1:0] core_one_channel_one_req,
  input wire [`CBAF_TARGETS*`CBAF_CTRL_W-1:0] core_one_channel_one_data,
  input wire [`CBAF_TARGETS-1:0] core_zero_channel_two_req,
  input wire [`CBAF_TARGETS*`CBAF_CTRL_W-1:0] core_zero_channel_two_data,
  input wire [`CBAF_TARGETS-1:0] core_one_channel_two_req,
  input wire [`CBAF_TARGETS*`CBAF_CTRL_W-1:0] core_one_channel_two_data,
  output wire [`CBAF_TARGETS*`CBAF_CTRL_W-1:0] target_control,
  output wire [`CBAF_TARGETS-1:0] target_update,
  input wire [`CBAF_TARGETS-1:0] feedback_raw,
  output wire [`CBAF_TARGETS-1:0] feedback_filtered,
  output wire [`CBAF_TARGETS-1:0] feedback_valid
);
  reg [`CBAF_GRANT_W-1:0] grants_channel1;
  reg [`CBAF_GRANT_W-1:0] grants_channel2;
  reg [`CBAF_FILTER_W-1:0] filter_one_two;
  reg [`CBAF_FILTER_W-1:0] filter_three_four_low;
  reg [`CBAF_FILTER_W-1:0] filter_four_high_negative;
  reg [`CBAF_SETTLING_W-1:0] settling_time;
  wire [`CBAF_FILTER_W*3-1:0] filter_all;
  wire [`CBAF_TARGETS-1:0] updated;

  // Reset words are 16 bits wide; only the implemented field bits are loaded.
  localparam [15:0] rst_grants_ch1 = `CBAF_RST_GRANTS_CH1;
  localparam [15:0] rst_grants_ch2 = `CBAF_RST_GRANTS_CH2;
  localparam [15:0] rst_filter = `CBAF_RST_FILTER;
  localparam [15:0] rst_settling = `CBAF_RST_SETTLING;

  assign filter_all = {filter_four_high_negative, filter_three_four_low, filter_one_two};
  assign target_update = updated;

  // Maps a target (1, 2, 3, 4L, 4H, 4neg) to its grant bit within one core's field.
  function [2:0] grant_bit;
    input integer target;
    begin
      if (target == 5) begin
        grant_bit = `CBAF_GRANT_4H_BIT;
      end else if (target == 3) begin
        grant_bit = `CBAF_GRANT_4L_BIT;
      end else begin
        grant_bit = target[2:0];
      end
    end
  endfunction

  // Register writes.
  always @(posedge sys_clk) begin
    if (srst) begin
      grants_channel1 <= rst_grants_ch1[`CBAF_GRANT_W-1:0];
      grants_channel2 <= rst_grants_ch2[`CBAF_GRANT_W-1:0];
      filter_one_two <= rst_filter[`CBAF_FILTER_W-1:0];
      filter_three_four_low <= rst_filter[`CBAF_FILTER_W-1:0];
      filter_four_high_negative <= rst_filter[`CBAF_FILTER_W-1:0];
      settling_time <= rst_settling[`CBAF_SETTLING_W-1:0];
    end else if (reg_wr) begin
      if (reg_addr == `CBAF_OFS_GRANTS_CH1) begin
        grants_channel1 <= reg_wdata[`CBAF_GRANT_W-1:0];
      end else if (reg_addr == `CBAF_OFS_GRANTS_CH2) begin
        grants_channel2 <= reg_wdata[`CBAF_GRANT_W-1:0];
      end else if (reg_addr == `CBAF_OFS_FILTER_12) begin
        filter_one_two <= reg_wdata[`CBAF_FILTER_W-1:0];
      end else if (reg_addr == `CBAF_OFS_FILTER_34L) begin
        filter_three_four_low <= reg_wdata[`CBAF_FILTER_W-1:0];
      end else if (reg_addr == `CBAF_OFS_FILTER_4H4NEG) begin
        filter_four_high_negative <= reg_wdata[`CBAF_FILTER_W-1:0];
      end else if (reg_addr == `CBAF_OFS_SETTLING) begin
        settling_time <= reg_wdata[`CBAF_SETTLING_W-1:0];
      end
    end
  end

  // Register reads; data stands for the one cycle after the strobe.
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `CBAF_OFS_GRANTS_CH1) begin
        reg_rdata <= {6'h00, grants_channel1};
      end else if (reg_addr == `CBAF_OFS_GRANTS_CH2) begin
        reg_rdata <= {6'h00, grants_channel2};
      end else if (reg_addr == `CBAF_OFS_FILTER_12) begin
        reg_rdata <= {4'h0, filter_one_two};
      end else if (reg_addr == `CBAF_OFS_FILTER_34L) begin
        reg_rdata <= {4'h0, filter_three_four_low};
      end else if (reg_addr == `CBAF_OFS_FILTER_4H4NEG) begin
        reg_rdata <= {4'h0, filter_four_high_negative};
      end else if (reg_addr == `CBAF_OFS_SETTLING) begin
        reg_rdata <= {10'h000, settling_time};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  genvar t;
  generate
    for (t = 0; t < `CBAF_TARGETS; t = t + 1) begin : g_target
      wire [`CBAF_CHANNELS-1:0] granted_req;
      wire [`CBAF_CHANNELS*`CBAF_CTRL_W-1:0] chan_data;
      wire [`CBAF_LEN_W-1:0] len;
      wire ftype;
      wire [`CBAF_INVALID_W-1:0] window;
      reg [`CBAF_INVALID_W-1:0] remaining;
      reg valid_q;

      // Channel order in the vector sets the priority, index 0 highest.
      assign granted_req[0] = core_zero_channel_one_req[t]
        & grants_channel1[grant_bit(t)];
      assign granted_req[1] = core_one_channel_one_req[t]
        & grants_channel1[`CBAF_GRANT_CORE1_BASE + grant_bit(t)];
      assign granted_req[2] = core_zero_channel_two_req[t]
        & grants_channel2[grant_bit(t)];
      assign granted_req[3] = core_one_channel_two_req[t]
        & grants_channel2[`CBAF_GRANT_CORE1_BASE + grant_bit(t)];
      assign chan_data = {
        core_one_channel_two_data[t*`CBAF_CTRL_W +: `CBAF_CTRL_W],
        core_zero_channel_two_data[t*`CBAF_CTRL_W +: `CBAF_CTRL_W],
        core_one_channel_one_data[t*`CBAF_CTRL_W +: `CBAF_CTRL_W],
        core_zero_channel_one_data[t*`CBAF_CTRL_W +: `CBAF_CTRL_W]};

      cbaf_target_arbiter u_arb (
        .sys_clk(sys_clk),
        .srst(srst),
        .req(granted_req),
        .req_data(chan_data),
        .control(target_control[t*`CBAF_CTRL_W +: `CBAF_CTRL_W]),
        .updated(updated[t])
      );

      assign len = filter_all[t*`CBAF_HALF_W + `CBAF_LEN_LSB +: `CBAF_LEN_W];
      assign ftype = filter_all[t*`CBAF_HALF_W + `CBAF_TYPE_BIT];

      cbaf_feedback_filter u_filt (
        .sys_clk(sys_clk),
        .srst(srst),
        .sample(feedback_raw[t]),
        .filter_type(ftype),
        .filter_length(len),
        .level(feedback_filtered[t])
      );

      assign window = {1'b0, settling_time} + {2'b00, len} + `CBAF_INVALID_EXTRA;

      assign feedback_valid[t] = valid_q;

      // The window counts from the cycle the new control value appears, so valid is taken
      // from the granted request and falls together with the update pulse.
      always @(posedge sys_clk) begin
        if (srst) begin
          remaining <= 7'h00;
          valid_q <= 1'b1;
        end else if (|granted_req) begin
          remaining <= window - 7'h01;
          valid_q <= 1'b0;
        end else if (remaining != 7'h00) begin
          remaining <= remaining - 7'h01;
          valid_q <= 1'b0;
        end else begin
          valid_q <= 1'b1;
        end
      end
    end
  endgenerate
endmodule

//--- logic/cbaf_consts.vh
// Constants for the current block access filter: register offsets, fields, resets, timing.
// Assumes the register port carries raw 9-bit offsets.
`ifndef CBAF_CONSTS_VH
`define CBAF_CONSTS_VH

`define CBAF_ADDR_W 9
`define CBAF_OFS_GRANTS_CH1 9'h188
`define CBAF_OFS_GRANTS_CH2 9'h189
`define CBAF_OFS_FILTER_12 9'h198
`define CBAF_OFS_FILTER_34L 9'h199
`define CBAF_OFS_FILTER_4H4NEG 9'h19a
`define CBAF_OFS_SETTLING 9'h1a9

`define CBAF_RST_GRANTS_CH1 16'h0041
`define CBAF_RST_GRANTS_CH2 16'h0304
`define CBAF_RST_FILTER 16'h0041
`define CBAF_RST_SETTLING 16'h0000

`define CBAF_GRANT_W 10
`define CBAF_GRANT_CORE1_BASE 5
`define CBAF_GRANT_4L_BIT 3'h3
`define CBAF_GRANT_4H_BIT 3'h4
`define CBAF_FILTER_W 12
`define CBAF_LEN_LSB 0
`define CBAF_LEN_W 5
`define CBAF_TYPE_BIT 5
`define CBAF_HALF_W 6
`define CBAF_SETTLING_W 6

`define CBAF_TARGETS 6
`define CBAF_CHANNELS 4
`define CBAF_CTRL_W 11
`define CBAF_INVALID_EXTRA 7'h04
`define CBAF_INVALID_W 7

`endif

//--- logic/cbaf_feedback_filter.v
// One current feedback filter with selectable reset or decrement behaviour.
// Assumes the sample is synchronous to sys_clk.
`timescale 1ns/100ps
`include "cbaf_consts.vh"
module cbaf_feedback_filter (
  input wire sys_clk,
  input wire srst,
  input wire sample,
  input wire filter_type,
  input wire [`CBAF_LEN_W-1:0] filter_length,
  output reg level
);
  reg [`CBAF_LEN_W-1:0] count;

  always @(posedge sys_clk) begin
    if (srst) begin
      level <= 1'b0;
      count <= 5'h00;
    end else if (sample != level) begin
      if (count >= filter_length) begin
        level <= sample;
        count <= 5'h00;
      end else begin
        count <= count + 5'h01;
      end
    end else if (filter_type) begin
      if (count != 5'h00) begin
        count <= count - 5'h01;
      end
    end else begin
      count <= 5'h00;
    end
  end
endmodule

//--- logic/cbaf_target_arbiter.v
// Fixed-priority merge of four channel requests onto one measure-block control set.
// Assumes requests arrive already gated by their access grants; index 0 is highest.
`timescale 1ns/100ps
`include "cbaf_consts.vh"
module cbaf_target_arbiter (
  input wire sys_clk,
  input wire srst,
  input wire [`CBAF_CHANNELS-1:0] req,
  input wire [`CBAF_CHANNELS*`CBAF_CTRL_W-1:0] req_data,
  output reg [`CBAF_CTRL_W-1:0] control,
  output reg updated
);
  // Each cycle's winner is applied at once, so requests in separate cycles all land in order.
  always @(posedge sys_clk) begin
    if (srst) begin
      control <= 11'h000;
      updated <= 1'b0;
    end else begin
      updated <= |req;
      if (req[0]) begin
        control <= req_data[0*`CBAF_CTRL_W +: `CBAF_CTRL_W];
      end else if (req[1]) begin
        control <= req_data[1*`CBAF_CTRL_W +: `CBAF_CTRL_W];
      end else if (req[2]) begin
        control <= req_data[2*`CBAF_CTRL_W +: `CBAF_CTRL_W];
      end else if (req[3]) begin
        control <= req_data[3*`CBAF_CTRL_W +: `CBAF_CTRL_W];
      end
    end
  end
endmodule

//--- verif/cbaf_checker_sva.sv
// Port-level assertions for the current block access filter.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module cbaf_checker (
  input wire sys_clk,
  input wire srst,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [5:0] core_zero_channel_one_req,
  input wire [5:0] core_one_channel_one_req,
  input wire [5:0] core_zero_channel_two_req,
  input wire [5:0] core_one_channel_two_req,
  input wire [65:0] target_control,
  input wire [5:0] target_update,
  input wire [5:0] feedback_raw,
  input wire [5:0] feedback_filtered,
  input wire [5:0] feedback_valid
);
  wire [5:0] rq = core_zero_channel_one_req | core_one_channel_one_req |
    core_zero_channel_two_req | core_one_channel_two_req;
  wire [5:0] tu = target_update;
  wire [5:0] fv = feedback_valid;
  wire [5:0] ff = feedback_filtered;
  wire [5:0] raw = feedback_raw;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  a_update_cause: assert property ((tu & ~$past(rq)) == 6'h00)
    else $error("update without a request");
  a_ctrl_holds: assert property (tu == 6'h00 |-> $stable(target_control))
    else $error("control changed without update");
  a_valid_drop: assert property (tu[0] |-> (!fv[0]) [*4])
    else $error("feedback valid too early");
  a_valid_low: assert property ((tu & fv) == 6'h00)
    else $error("valid high during update");
  a_valid_cause: assert property (($past(fv) & ~fv & ~tu) == 6'h00)
    else $error("valid fell without update");
  a_filt_tracks: assert property ((($past(ff) ^ ff) & (ff ^ $past(raw))) == 6'h00)
    else $error("filter flipped against input");
  a_filt_stable: assert property ((($past(ff) ^ ff) & (ff ^ $past(raw, 2))) == 6'h00)
    else $error("filter flipped too soon");
endmodule
bind cbaf_current_block_access_filter cbaf_checker i_cbaf_checker (
  .sys_clk(sys_clk), .srst(srst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_zero_channel_one_req(core_zero_channel_one_req),
  .core_one_channel_one_req(core_one_channel_one_req),
  .core_zero_channel_two_req(core_zero_channel_two_req),
  .core_one_channel_two_req(core_one_channel_two_req),
  .target_control(target_control), .target_update(target_update),
  .feedback_raw(feedback_raw), .feedback_filtered(feedback_filtered),
  .feedback_valid(feedback_valid));

//--- verif/cbaf_core.sv
// Behavioural microcore channel that pulses control-change requests per block.
// Assumes one send at a time per instance, called from the bench.
`timescale 1ns/100ps
module cbaf_core (
  input wire sys_clk,
  output logic [5:0] req,
  output logic [65:0] data
);
  initial begin
    req = 6'h00;
    data = '1;
  end
  // Released data lines show the inverse of the last word.
  task automatic send(input int t, input logic [10:0] v, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    req[t] <= 1'b1;
    data[t*11+:11] <= v;
    @(posedge sys_clk);
    req[t] <= 1'b0;
    data[t*11+:11] <= ~v;
  endtask
endmodule

//--- verif/cbaf_current_block_access_filter_tb_top.sv
// Self-checking bench for the current block access filter with four channel models.
// Assumes one 200 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
module cbaf_current_block_access_filter_tb_top;
  typedef struct {logic [8:0] a; logic [15:0] d;} cbaf_row_t;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] raw = 6'h00;
  logic [15:0] reg_rdata;
  logic [5:0] r0, r1, r2, r3, tu, ff, fv;
  logic [65:0] d0, d1, d2, d3, tc;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  cbaf_row_t rows[7] = '{'{9'h188, 16'h0041}, '{9'h189, 16'h0304}, '{9'h198, 16'h0041},
    '{9'h199, 16'h0041}, '{9'h19a, 16'h0041}, '{9'h1a9, 16'h0000}, '{9'h000, 16'h0000}};
  always #2.5 sys_clk = ~sys_clk;
  cbaf_core i_cbaf_core_0 (.sys_clk(sys_clk), .req(r0), .data(d0));
  cbaf_core i_cbaf_core_1 (.sys_clk(sys_clk), .req(r1), .data(d1));
  cbaf_core i_cbaf_core_2 (.sys_clk(sys_clk), .req(r2), .data(d2));
  cbaf_core i_cbaf_core_3 (.sys_clk(sys_clk), .req(r3), .data(d3));
  cbaf_current_block_access_filter i_cbaf_current_block_access_filter (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_zero_channel_one_req(r0), .core_zero_channel_one_data(d0),
    .core_one_channel_one_req(r1), .core_one_channel_one_data(d1),
    .core_zero_channel_two_req(r2), .core_zero_channel_two_data(d2),
    .core_one_channel_two_req(r3), .core_one_channel_two_data(d3),
    .target_control(tc), .target_update(tu), .feedback_raw(raw),
    .feedback_filtered(ff), .feedback_valid(fv));
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, e);
  endtask
  // Channels named in the mask request target t together, each with its own word.
  task automatic multi(input logic [3:0] m, input int t);
    fork
      if (m[0]) i_cbaf_core_0.send(t, 11'h101, 0);
      if (m[1]) i_cbaf_core_1.send(t, 11'h102, 0);
      if (m[2]) i_cbaf_core_2.send(t, 11'h103, 0);
      if (m[3]) i_cbaf_core_3.send(t, 11'h104, 0);
    join
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    foreach (rows[i]) rd(rows[i].a, rows[i].d);
    multi(4'b0010, 0);
    check("ctl0 refused", tc[10:0], 11'h000);
    check("update refused", 16'(tu), 16'h0000);
    multi(4'b0001, 0);
    check("ctl0 granted", tc[10:0], 11'h101);
    check("update granted", 16'(tu), 16'h0001);
    wr(9'h188, 16'hffff);
    wr(9'h189, 16'hffff);
    rd(9'h189, 16'h03ff);
    for (int k = 3; k >= 0; k--) begin
      multi(4'(4'b1111 << k), 0);
      check("priority", tc[10:0], 16'(11'h101 + k));
    end
    fork
      i_cbaf_core_3.send(2, 11'h0aa, 0);
      i_cbaf_core_0.send(2, 11'h055, 1);
      begin
        repeat (2) @(posedge sys_clk);
        #1;
        check("first of two", tc[32:22], 11'h0aa);
      end
    join
    #1;
    check("second of two", tc[32:22], 11'h055);
    wr(9'h198, 16'h08c3);
    wr(9'h1a9, 16'h0002);
    raw <= 6'h03;
    repeat (3) @(posedge sys_clk);
    raw <= 6'h00;
    @(posedge sys_clk);
    raw <= 6'h03;
    repeat (2) @(posedge sys_clk);
    #1;
    check("decrement type", ff[1:0], 2'b10);
    repeat (2) @(posedge sys_clk);
    #1;
    check("clearing type", ff[1:0], 2'b11);
    i_cbaf_core_0.send(0, 11'h033, 0);
    #1;
    n = 0;
    while (fv[0] !== 1'b1 && n < 200) begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    check("invalid window", 16'(n), 16'h0009);
    wr(9'h188, 16'h0008);
    multi(4'b0001, 3);
    check("update 4 low", 16'(tu), 16'h0008);
    multi(4'b0001, 4);
    check("update 4 high", 16'(tu), 16'h0000);
    check("block 4 low", tc[43:33], 11'h101);
    check("block 4 high", tc[54:44], 11'h000);
    wr(9'h188, 16'h0010);
    multi(4'b0001, 5);
    check("block 4 negative", tc[65:55], 11'h101);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rd(9'h188, 16'h0041);
    check("control reset", tc[10:0], 11'h000);
    report_and_stop();
  end
endmodule
